//--- bench/dhwi_host_model.sv
// Purpose: host side model, I2C master plus parallel bus master
// Assumes: SDA pull-up resolved by the testbench
// Notes:   pins move on sys_clk falling edges; SCL half period 10 cycles
`timescale 1ns/1ps
module dhwi_host_model (
  input  wire logic        sys_clk,
  input  wire logic        sda_line,
  output logic             scl,
  output logic             sda_low,
  output logic             cs_n,
  output logic             wr_n,
  output logic [4:0]       channel_address,
  output logic             register_select_hi,
  output logic             register_select_lo,
  output logic [13:0]      parallel_data_word
);
  // Idle bus, port deselected
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    cs_n = 1'b1;
    wr_n = 1'b1;
    channel_address = 5'h00;
    {register_select_hi, register_select_lo} = 2'h0;
    parallel_data_word = 14'h0000;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Start: SDA falls while SCL high
  task automatic start();
    sda_low = 1'b1;
    hold(5);
    scl = 1'b0;
    hold(5);
  endtask
  // Stop: SDA rises while SCL high
  task automatic stop();
    sda_low = 1'b1;
    hold(5);
    scl = 1'b1;
    hold(5);
    sda_low = 1'b0;
    hold(10);
  endtask
  // MSB first, then release SDA and sample the ninth bit
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      hold(5);
      scl = 1'b1;
      hold(10);
      scl = 1'b0;
      hold(5);
    end
    sda_low = 1'b0;
    hold(5);
    scl = 1'b1;
    hold(5);
    ack = ~sda_line;
    hold(5);
    scl = 1'b0;
    hold(5);
  endtask
  // Select bits over upper six, then lower eight
  task automatic send_pair(input logic [1:0] s, input logic [13:0] v,
                           output logic ack);
    logic a1;
    send_byte({s, v[13:8]}, a1);
    send_byte(v[7:0], ack);
    ack = ack & a1;
  endtask
  // Strobe rises with everything held; bus scrambled afterwards
  task automatic par_write(input logic c, input logic [4:0] ch,
                           input logic [1:0] s, input logic [13:0] d);
    cs_n = c;
    channel_address = ch;
    {register_select_hi, register_select_lo} = s;
    parallel_data_word = d;
    wr_n = 1'b0;
    hold(5);
    wr_n = 1'b1;
    hold(5);
    cs_n = 1'b1;
    channel_address = ~ch;
    parallel_data_word = ~d;
    hold(3);
  endtask
endmodule

//--- bench/testbench.sv
// Purpose: self-checking bench for the DAC host write front end
// Assumes: straps at 10, so the slave address is 1010110, save one scenario
// Notes:   every channel write is queued by a monitor and compared
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] ADR_W = 8'hAC;
  logic        sys_clk, rst_n, isel, scl, sda_low, sda_out, sda_oe, a;
  logic        cs_n, wr_n, rhi, rlo, wv, burst, tblk, sth, stl;
  logic [4:0]  cha, wch;
  logic [1:0]  wreg;
  logic [13:0] pdw, wdat;
  logic [20:0] wq[$];
  int          err_count, samples_checked, drops, cyc;
  wire         sda_line = ~(sda_oe & ~sda_out) & ~sda_low;
  dhwi_host_model m (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl),
    .sda_low(sda_low), .cs_n(cs_n), .wr_n(wr_n), .channel_address(cha),
    .register_select_hi(rhi), .register_select_lo(rlo), .parallel_data_word(pdw));
  dhwi_core dut (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .slave_strap_hi(sth), .slave_strap_lo(stl),
    .interface_select(isel), .cs_n(cs_n), .wr_n(wr_n), .channel_address(cha),
    .register_select_hi(rhi), .register_select_lo(rlo), .parallel_data_word(pdw),
    .write_valid(wv), .write_channel(wch), .write_register(wreg), .write_data(wdat),
    .burst_active(burst), .toggle_blocked(tblk));
  // 100 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Monitor and hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (wv === 1'b1) wq.push_back({wch, wreg, wdat});
    if (tblk === 1'b1) drops <= drops + 1;
    if (cyc == 40000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask
  task automatic check_wr(input logic [4:0] c, input logic [1:0] r, input logic [13:0] d);
    logic [20:0] got;
    got = 'x;
    if (wq.size() > 0) got = wq.pop_front();
    check_bit(got === {c, r, d}, 1'b1, "write mismatch");
  endtask
  task automatic byte_ack(input logic [7:0] b, input logic exp);
    m.send_byte(b, a);
    check_bit(a, exp, "ack");
  endtask
  task automatic open_tx(input logic [7:0] p);
    m.start();
    byte_ack(ADR_W, 1'b1);
    byte_ack(p, 1'b1);
  endtask
  task automatic pair(input logic [1:0] s, input logic [13:0] v);
    m.send_pair(s, v, a);
    check_bit(a, 1'b1, "data ack");
  endtask
  initial begin
    {err_count, samples_checked, drops, cyc} = '0;
    rst_n = 1'b0;
    isel = 1'b1;
    {sth, stl} = 2'h2;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    m.hold(5);
    check_bit(sda_oe | wv | burst, 1'b0, "reset outputs");
    // Foreign strap value, then read direction: both ignored
    m.start();
    byte_ack(8'hAA, 1'b0);
    m.stop();
    m.start();
    byte_ack(8'hAD, 1'b0);
    m.stop();
    // Other strap setting moves the address
    {sth, stl} = 2'h1;
    m.hold(5);
    m.start();
    byte_ack(8'hAA, 1'b1);
    m.stop();
    {sth, stl} = 2'h2;
    m.hold(5);
    // Every select code, one address byte, pointer per update
    open_tx(8'h04);
    for (int s = 0; s < 4; s++) begin
      if (s != 0) byte_ack(8'h04 + 8'(s), 1'b1);
      pair(2'(s), 14'h2A5C + 14'(s));
      check_wr(5'h04 + 5'(s), 2'(s), 14'h2A5C + 14'(s));
    end
    m.stop();
    // Burst through all channels, then back to pointer mode
    open_tx(8'hFF);
    check_bit(burst, 1'b1, "burst entry");
    for (int i = 0; i < 32; i++) begin
      pair(2'h3, 14'h3FFF - 14'(i));
      check_wr(5'(i), 2'h3, 14'h3FFF - 14'(i));
    end
    check_bit(burst, 1'b0, "burst exit");
    byte_ack(8'h1F, 1'b1);
    pair(2'h1, 14'h0001);
    check_wr(5'h1F, 2'h1, 14'h0001);
    m.stop();
    // Toggle write dropped; stop mid-pair leaves burst
    open_tx(8'hFF);
    pair(2'h0, 14'h1234);
    check_bit(drops == 1, 1'b1, "toggle drop");
    byte_ack(8'h80, 1'b1);
    m.stop();
    check_bit(burst, 1'b0, "stop ends burst");
    open_tx(8'h02);
    pair(2'h2, 14'h0100);
    check_wr(5'h02, 2'h2, 14'h0100);
    m.stop();
    // Parallel port: write, deselected strobe, serial disabled
    isel = 1'b0;
    m.hold(5);
    m.par_write(1'b0, 5'h09, 2'h2, 14'h2001);
    check_wr(5'h09, 2'h2, 14'h2001);
    m.par_write(1'b1, 5'h0A, 2'h3, 14'h1555);
    m.start();
    byte_ack(ADR_W, 1'b0);
    m.stop();
    check_bit(wq.size() == 0, 1'b1, "stray write");
    end_sim();
  end
endmodule

//--- rtl/dhwi_core.sv
// Purpose: I2C write path and parallel write port of a 32-channel DAC front end
// Assumes: SCL well below sys_clk/8; all pins synchronised on sys_clk
// Notes:   emits one write pulse per completed channel update
`timescale 1ns/1ps

module dhwi_core (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        slave_strap_hi,
  input  wire logic        slave_strap_lo,
  input  wire logic        interface_select,
  input  wire logic        cs_n,
  input  wire logic        wr_n,
  input  wire logic [4:0]  channel_address,
  input  wire logic        register_select_hi,
  input  wire logic        register_select_lo,
  input  wire logic [13:0] parallel_data_word,
  output logic             write_valid,
  output logic [4:0]       write_channel,
  output logic [1:0]       write_register,
  output logic [13:0]      write_data,
  output logic             burst_active,
  output logic             toggle_blocked
);
  typedef enum logic [2:0] {
    DHWI_IDLE, DHWI_ADDR, DHWI_PTR, DHWI_DHI, DHWI_DLO, DHWI_SKIP
  } dhwi_state_t;

  logic       scl_s;
  logic       sda_s;
  logic       sel_s;
  logic       cs_n_s;
  logic       wr_n_s;
  logic [4:0] chan_s;
  logic [1:0] reg_s;
  logic [13:0] pdata_s;
  logic [1:0]  strap_s;

  // All pins cross into sys_clk; bus idles high, straps read as zero in reset
  dhwi_sync #(.WIDTH(5), .INIT(32'h0000_001C)) u_sync_i2c (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin_in  ({scl_in, sda_in, interface_select,
               slave_strap_hi, slave_strap_lo}),
    .pin_out ({scl_s, sda_s, sel_s, strap_s})
  );
  dhwi_sync #(.WIDTH(23), .INIT(32'h0000_0003)) u_sync_par (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin_in  ({channel_address, register_select_hi, register_select_lo,
               parallel_data_word, cs_n, wr_n}),
    .pin_out ({chan_s, reg_s, pdata_s, cs_n_s, wr_n_s})
  );

  dhwi_state_t state_q, state_d;
  logic        scl_q, scl_d;
  logic        sda_q, sda_d;
  logic [3:0]  bit_q, bit_d;
  logic [7:0]  shift_q, shift_d;
  logic        ack_q, ack_d;
  logic        burst_q, burst_d;
  logic [4:0]  ptr_q, ptr_d;
  logic [7:0]  hi_q, hi_d;
  logic        wv_q, wv_d;
  logic [4:0]  wch_q, wch_d;
  logic [1:0]  wrg_q, wrg_d;
  logic [13:0] wdt_q, wdt_d;
  logic        tog_q, tog_d;
  logic        wr_n_q;

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic ser_en;
  logic [7:0] byte_c;

  // Bus events seen from synchronised samples only
  always_comb begin
    scl_d    = scl_s;
    sda_d    = sda_s;
    ser_en   = sel_s;
    scl_rise = scl_s & ~scl_q;
    scl_fall = ~scl_s & scl_q;
    start_c  = ser_en & scl_s & scl_q & sda_q & ~sda_s;
    stop_c   = ser_en & scl_s & scl_q & ~sda_q & sda_s;
    byte_c   = {shift_q[6:0], sda_s};
  end

  // Byte engine and write sequencer
  always_comb begin
    state_d = state_q;
    bit_d   = bit_q;
    shift_d = shift_q;
    ack_d   = ack_q;
    burst_d = burst_q;
    ptr_d   = ptr_q;
    hi_d    = hi_q;
    wv_d    = 1'b0;
    wch_d   = wch_q;
    wrg_d   = wrg_q;
    wdt_d   = wdt_q;
    tog_d   = 1'b0;
    if (!ser_en) begin
      // Parallel port owns the channel registers
      state_d = DHWI_IDLE;
      burst_d = 1'b0;
      ack_d   = 1'b0;
      if (wr_n_s && !wr_n_q && !cs_n_s) begin
        wv_d  = 1'b1;
        wch_d = chan_s;
        wrg_d = reg_s;
        wdt_d = pdata_s;
      end
    end else if (stop_c) begin
      state_d = DHWI_IDLE;
      burst_d = 1'b0;
      ack_d   = 1'b0;
    end else if (start_c) begin
      state_d = DHWI_ADDR;
      bit_d   = 4'h0;
      ack_d   = 1'b0;
      burst_d = 1'b0;
    end else if (scl_fall && state_q != DHWI_IDLE) begin
      if (ack_q) begin
        ack_d = 1'b0;                                       // Release after ninth clock
        bit_d = 4'h0;
      end else if (bit_q == dhwi_pkg::BITS_PER_BYTE) begin
        bit_d = 4'h0;
        // Byte complete: decide, and acknowledge unless the address mismatches or the byte is skipped
        unique case (state_q)
          DHWI_ADDR: begin
            if (shift_q == {dhwi_pkg::ADDR_FIXED, strap_s, 1'b0}) begin
              ack_d   = 1'b1;
              state_d = DHWI_PTR;
            end else begin
              state_d = DHWI_SKIP;
            end
          end
          DHWI_PTR: begin
            ack_d   = 1'b1;
            state_d = DHWI_DHI;
            if (shift_q == dhwi_pkg::BURST_POINTER) begin
              burst_d = 1'b1;
              ptr_d   = dhwi_pkg::FIRST_CHANNEL;
            end else begin
              ptr_d   = shift_q[dhwi_pkg::CHAN_WIDTH-1:0];
            end
          end
          DHWI_DHI: begin
            ack_d   = 1'b1;
            hi_d    = shift_q;
            state_d = DHWI_DLO;
          end
          DHWI_DLO: begin
            ack_d = 1'b1;
            wrg_d = hi_q[dhwi_pkg::REG_SEL_HI_POS:dhwi_pkg::REG_SEL_LO_POS];
            wch_d = ptr_q;
            wdt_d = {hi_q[dhwi_pkg::VAL_HI_TOP:0], shift_q};
            // Toggle registers are not reachable in burst
            if (burst_q && hi_q[dhwi_pkg::REG_SEL_HI_POS:dhwi_pkg::REG_SEL_LO_POS]
                == 2'h0) begin
              tog_d = 1'b1;
            end else begin
              wv_d = 1'b1;
            end
            if (burst_q && ptr_q != dhwi_pkg::LAST_CHANNEL) begin
              ptr_d   = 5'(ptr_q + 5'h01);
              state_d = DHWI_DHI;
            end else begin
              burst_d = 1'b0;
              state_d = DHWI_PTR;
            end
          end
          default: state_d = DHWI_SKIP;
        endcase
      end
    end else if (scl_rise && state_q != DHWI_IDLE && !ack_q
                 && bit_q != dhwi_pkg::BITS_PER_BYTE) begin
      shift_d = byte_c;
      bit_d   = 4'(bit_q + 4'h1);
    end
  end

  // Register stage; outputs straight from flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= DHWI_IDLE;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      bit_q   <= 4'h0;
      shift_q <= 8'h00;
      ack_q   <= 1'b0;
      burst_q <= 1'b0;
      ptr_q   <= 5'h00;
      hi_q    <= 8'h00;
      wv_q    <= 1'b0;
      wch_q   <= 5'h00;
      wrg_q   <= 2'h0;
      wdt_q   <= 14'h0000;
      tog_q   <= 1'b0;
      wr_n_q  <= 1'b1;
    end else begin
      state_q <= state_d;
      scl_q   <= scl_d;
      sda_q   <= sda_d;
      bit_q   <= bit_d;
      shift_q <= shift_d;
      ack_q   <= ack_d;
      burst_q <= burst_d;
      ptr_q   <= ptr_d;
      hi_q    <= hi_d;
      wv_q    <= wv_d;
      wch_q   <= wch_d;
      wrg_q   <= wrg_d;
      wdt_q   <= wdt_d;
      tog_q   <= tog_d;
      wr_n_q  <= wr_n_s;
    end
  end

  // Acknowledge pulls data low; open drain so output is constant low
  assign sda_out        = 1'b0;
  assign sda_oe         = ack_q;
  assign write_valid    = wv_q;
  assign write_channel  = wch_q;
  assign write_register = wrg_q;
  assign write_data     = wdt_q;
  assign burst_active   = burst_q;
  assign toggle_blocked = tog_q;

  // Stop always returns to idle
  stop_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stop_c |=> state_q == DHWI_IDLE && !burst_q)
    else $error("stop did not end transfer");

  // Burst pointer begins at channel zero
  burst_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(burst_q) |-> ptr_q == dhwi_pkg::FIRST_CHANNEL)
    else $error("burst did not start at channel zero");

  // Serial disabled keeps bus released
  par_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !sel_s |=> !sda_oe)
    else $error("serial active while parallel selected");

  // Parallel write needs select low
  par_select_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wv_q && !sel_s && !$past(sel_s) |-> !$past(cs_n_s))
    else $error("parallel write without select");

  // Strobe rise captures data word
  par_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !sel_s && !cs_n_s && wr_n_s && !wr_n_q |=> wv_q && wdt_q == $past(pdata_s))
    else $error("parallel word not latched");

  // Last burst channel reverts to pointer wait
  burst_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ser_en && !stop_c && !start_c && scl_fall && !ack_q && bit_q == dhwi_pkg::BITS_PER_BYTE
    && state_q == DHWI_DLO && burst_q && ptr_q == dhwi_pkg::LAST_CHANNEL
    |=> !burst_q && state_q == DHWI_PTR)
    else $error("burst did not end after last channel");

  // Acknowledge held for the whole ninth clock
  ack_span_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sda_oe && ser_en && !scl_fall && !stop_c && !start_c |=> sda_oe)
    else $error("acknowledge released early");

  // Acknowledge freed at the fall that ends the ninth clock
  ack_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sda_oe && scl_fall |=> !sda_oe)
    else $error("acknowledge held past ninth clock");

  // Data pair write carries register select
  pair_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wv_q && ser_en && $past(ser_en)
    |-> wrg_q == $past(hi_q[dhwi_pkg::REG_SEL_HI_POS:dhwi_pkg::REG_SEL_LO_POS]))
    else $error("register select mismatch");

  // Dropped toggle pair never writes and only happens in burst
  toggle_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tog_q |-> !wv_q && $past(burst_q))
    else $error("toggle write not dropped");
endmodule

//--- rtl/dhwi_pkg.sv
// Purpose: shared constants for the DAC host write front end
// Assumes: 10 MHz system clock, 7-bit slave address, 32 channels
// Notes:   field positions and codes for the core design file; DATA_WIDTH and SEL_WIDTH are not used there
package dhwi_pkg;
  localparam logic [4:0] ADDR_FIXED     = 5'h15;  // Upper five address bits 10101
  localparam logic [7:0] BURST_POINTER  = 8'hFF;  // Pointer code entering burst mode
  localparam logic [4:0] FIRST_CHANNEL  = 5'h00;
  localparam logic [4:0] LAST_CHANNEL   = 5'h1F;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;   // Ninth bit is the acknowledge slot
  localparam int         REG_SEL_HI_POS = 7;      // Register select in first data byte
  localparam int         REG_SEL_LO_POS = 6;
  localparam int         VAL_HI_TOP     = 5;      // Upper six value bits of first byte
  localparam int         DATA_WIDTH     = 14;
  localparam int         CHAN_WIDTH     = 5;
  localparam int         SEL_WIDTH      = 2;
endpackage

//--- rtl/dhwi_sync.sv
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to sys_clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module dhwi_sync #(
  parameter int          WIDTH = 1,
  parameter logic [31:0] INIT  = 32'h0000_0000
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] out_d;

  // Next values: shift one stage per clock
  always_comb begin
    meta_d = pin_in;
    out_d  = meta_q;
  end

  // Reset to the idle level so no false edge follows release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT[WIDTH-1:0];
      out_q  <= INIT[WIDTH-1:0];
    end else begin
      meta_q <= meta_d;
      out_q  <= out_d;
    end
  end

  assign pin_out = out_q;
endmodule
